// ---- src/oag_pkg.sv ----
// Shared constants and decode helpers for the operand address generator
package oag_pkg;

  // Addressing mode codes presented with each request
  localparam int MODE_W = 5;
  localparam logic [4:0] MODE_INH = 5'h00;
  localparam logic [4:0] MODE_IMM = 5'h01;
  localparam logic [4:0] MODE_DIR_S = 5'h02;
  localparam logic [4:0] MODE_DIR_L = 5'h03;
  localparam logic [4:0] MODE_IDX_N = 5'h04;
  localparam logic [4:0] MODE_IDX_S = 5'h05;
  localparam logic [4:0] MODE_IDX_L = 5'h06;
  localparam logic [4:0] MODE_IND_S = 5'h07;
  localparam logic [4:0] MODE_IND_L = 5'h08;
  localparam logic [4:0] MODE_IIX_S = 5'h09;
  localparam logic [4:0] MODE_IIX_L = 5'h0A;
  localparam logic [4:0] MODE_REL_D = 5'h0B;
  localparam logic [4:0] MODE_REL_I = 5'h0C;
  localparam logic [4:0] MODE_BIT_D = 5'h0D;
  localparam logic [4:0] MODE_BIT_I = 5'h0E;
  localparam logic [4:0] MODE_BIT_DR = 5'h0F;
  localparam logic [4:0] MODE_BIT_IR = 5'h10;
  localparam logic [4:0] MODE_COUNT = 5'h11;

  // Instruction length in bytes, opcode included
  localparam int LEN_W = 3;
  localparam logic [2:0] LEN_ONE = 3'h1;
  localparam logic [2:0] LEN_TWO = 3'h2;
  localparam logic [2:0] LEN_THREE = 3'h3;
  localparam logic [2:0] LEN_FOUR = 3'h4;

  // Adder operation kinds
  localparam logic [1:0] SUM_FULL = 2'h0;
  localparam logic [1:0] SUM_SHORT = 2'h1;
  localparam logic [1:0] SUM_REL = 2'h2;

  // Address constants
  localparam logic [7:0] PAGE0_HI = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;
  localparam logic [15:0] SHORT_SUM_MAX = 16'h01FE;
  localparam logic [15:0] PAGE0_MAX = 16'h00FF;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH_A = 4'h2,
    ST_FETCH_B = 4'h4,
    ST_CALC = 4'h8
  } oag_state_e;

  function automatic logic [2:0] oag_mode_len(input logic [4:0] mode,
                                              input logic use_y);
    case (mode)
      MODE_INH: oag_mode_len = LEN_ONE;
      MODE_IDX_N: oag_mode_len = use_y ? LEN_TWO : LEN_ONE;
      MODE_IMM, MODE_DIR_S, MODE_IDX_S, MODE_REL_D, MODE_BIT_D:
        oag_mode_len = LEN_TWO;
      MODE_BIT_IR: oag_mode_len = LEN_FOUR;
      MODE_COUNT: oag_mode_len = LEN_ONE;
      default: oag_mode_len = (mode > MODE_COUNT) ? LEN_ONE : LEN_THREE;
    endcase
  endfunction

  function automatic logic oag_needs_ptr(input logic [4:0] mode);
    oag_needs_ptr = (mode == MODE_IND_S) || (mode == MODE_IND_L) ||
                    (mode == MODE_IIX_S) || (mode == MODE_IIX_L) ||
                    (mode == MODE_REL_I) || (mode == MODE_BIT_I) ||
                    (mode == MODE_BIT_IR);
  endfunction

  function automatic logic oag_word_ptr(input logic [4:0] mode);
    oag_word_ptr = (mode == MODE_IND_L) || (mode == MODE_IIX_L);
  endfunction

  // Forms a read-modify-write instruction may use
  function automatic logic oag_short_form(input logic [4:0] mode);
    oag_short_form = (mode == MODE_INH) || (mode == MODE_DIR_S) ||
                     (mode == MODE_IDX_N) || (mode == MODE_IDX_S) ||
                     (mode == MODE_IND_S) || (mode == MODE_IIX_S) ||
                     (mode == MODE_BIT_D) || (mode == MODE_BIT_I) ||
                     (mode == MODE_BIT_DR) || (mode == MODE_BIT_IR);
  endfunction

endpackage

// ---- src/oag_sum_if.sv ----
// Operand bundle between the sequencer and the address adder
`timescale 1ns/10ps
interface oag_sum_if;
  logic [15:0] base;
  logic [7:0] addend;
  logic [1:0] kind;
  logic [15:0] result;

  modport req (output base, output addend, output kind, input result);
  modport calc (input base, input addend, input kind, output result);
endinterface

// ---- src/oag_adder.sv ----
// Address adder: page-zero short sums, full sums and relative targets
`timescale 1ns/10ps
module oag_adder (
  // Operands and result
  oag_sum_if.calc sum
);

  wire [8:0] short_sum;
  wire [15:0] full_sum;
  wire [15:0] rel_sum;

  // Carry out of bit 7 kept as address bit 8 (see [RQ18])
  assign short_sum = {1'b0, sum.base[7:0]} + {1'b0, sum.addend};
  // Unsigned index plus offset (see [RQ7])
  assign full_sum = sum.base + {oag_pkg::BYTE_ZERO, sum.addend};
  // Signed byte offset around the next-instruction address (see [RQ15])
  assign rel_sum = sum.base + {{8{sum.addend[7]}}, sum.addend};

  assign sum.result = (sum.kind == oag_pkg::SUM_SHORT) ?
                      {7'h00, short_sum} :
                      (sum.kind == oag_pkg::SUM_REL) ? rel_sum : full_sum;

endmodule

// ---- src/oag_addr_gen.sv ----
// Operand address generator and instruction length decoder
`timescale 1ns/10ps
//
// Contract
// [RQ1] Seventeen addressing modes in seven groups are decoded.
// [RQ2] Inherent instructions are one byte, opcode only.
// [RQ3] Immediate instructions are two bytes, no memory access.
// [RQ4] Immediate operand is the byte right after the opcode.
// [RQ5] Short direct uses the following byte as address, 00 to FF.
// [RQ6] Long direct uses two following bytes as a full 16-bit address.
// [RQ7] Indexed address is unsigned sum of X or Y and the offset.
// [RQ8] No-offset indexed: no extra byte with X, one with Y; range 00-FF.
// [RQ9] Short indexed: byte offset plus index, range 00 to 1FE.
// [RQ10] Long indexed: word offset plus index, full 64K range.
// [RQ11] Indirect: page-zero pointer address follows; word pointer reaches 64K.
// [RQ12] Short indirect reads a byte pointer, operand within 00 to FF.
// [RQ13] Indirect indexed: fetched pointer plus index, unsigned.
// [RQ14] Short indirect indexed gives addresses from 00 to 1FE.
// [RQ15] Relative target is next-instruction PC plus signed byte offset.
// [RQ16] Short forms stay in page zero and are shorter than long ones; here short indexed reaches 1FE and indirect is 3 bytes in both forms.
// [RQ17] Read-modify-write instructions accept only short forms.
// [RQ18] Short sums keep bit-7 carry as bit 8, upper bits zero.
module oag_addr_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Request from the decode stage
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [4:0] req_mode,
  input wire logic req_use_y,
  input wire logic req_rmw,
  input wire logic [15:0] req_pc,
  input wire logic [7:0] req_x,
  input wire logic [7:0] req_y,
  input wire logic [7:0] req_byte1,
  input wire logic [7:0] req_byte2,
  // Page-zero pointer fetch
  output logic mem_rd,
  output logic [15:0] mem_addr,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  // Result
  output logic done,
  output logic [15:0] ea,
  output logic [15:0] target,
  output logic [7:0] imm_data,
  output logic [2:0] inst_len,
  output logic illegal
);

  oag_pkg::oag_state_e state_reg, state_next;
  logic [4:0] mode_reg;
  logic use_y_reg, rmw_reg, bad_reg;
  logic [15:0] pc_reg;
  logic [7:0] x_reg, y_reg, b1_reg, b2_reg;
  logic [7:0] ptr_hi_reg, ptr_lo_reg;
  logic done_reg;
  logic [15:0] ea_reg, target_reg;
  logic [7:0] imm_reg;
  logic [2:0] len_reg;
  logic illegal_reg;

  wire req_fire;
  wire req_bad;
  wire req_ptr;
  wire st_idle, st_a, st_b, st_calc;
  wire [7:0] idx_val;
  wire [15:0] ptr_word;
  wire [15:0] pc_step;
  wire is_rel, is_short_sum, is_full_sum;
  wire [15:0] ea_next, target_next;
  wire [7:0] imm_next;
  wire [2:0] len_next;

  oag_sum_if sum_bus ();

  oag_adder u_adder (
    .sum(sum_bus)
  );

  assign st_idle = state_reg == oag_pkg::ST_IDLE;
  assign st_a = state_reg == oag_pkg::ST_FETCH_A;
  assign st_b = state_reg == oag_pkg::ST_FETCH_B;
  assign st_calc = state_reg == oag_pkg::ST_CALC;

  assign req_ready = st_idle;
  assign req_fire = req_valid && st_idle;
  // Unknown codes and long forms on read-modify-write are refused
  assign req_bad = (req_mode >= oag_pkg::MODE_COUNT) ||
                   (req_rmw && !oag_pkg::oag_short_form(req_mode)); // see [RQ17]
  assign req_ptr = oag_pkg::oag_needs_ptr(req_mode) && !req_bad; // see [RQ11]

  // Pointer always sits in page zero; second byte wraps there too
  assign mem_rd = st_a || st_b; // see [RQ11]
  assign pc_step = {oag_pkg::PAGE0_HI, b1_reg + oag_pkg::PTR_STEP};
  assign mem_addr = st_b ? pc_step : {oag_pkg::PAGE0_HI, b1_reg};

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      oag_pkg::ST_IDLE:
      begin
        if (req_fire)
          state_next = req_ptr ? oag_pkg::ST_FETCH_A : oag_pkg::ST_CALC;
      end
      oag_pkg::ST_FETCH_A:
      begin
        if (mem_ready)
          state_next = oag_pkg::oag_word_ptr(mode_reg) ?
                       oag_pkg::ST_FETCH_B : oag_pkg::ST_CALC;
      end
      oag_pkg::ST_FETCH_B:
      begin
        if (mem_ready)
          state_next = oag_pkg::ST_CALC;
      end
      oag_pkg::ST_CALC:
        state_next = oag_pkg::ST_IDLE;
      default:
        state_next = oag_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      state_reg <= oag_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Capture of the request fields
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_reg <= oag_pkg::MODE_INH;
      use_y_reg <= 1'b0;
      rmw_reg <= 1'b0;
      bad_reg <= 1'b0;
      pc_reg <= oag_pkg::ADDR_ZERO;
      x_reg <= oag_pkg::BYTE_ZERO;
      y_reg <= oag_pkg::BYTE_ZERO;
      b1_reg <= oag_pkg::BYTE_ZERO;
      b2_reg <= oag_pkg::BYTE_ZERO;
    end
    else if (req_fire)
    begin
      mode_reg <= req_mode;
      use_y_reg <= req_use_y;
      rmw_reg <= req_rmw;
      bad_reg <= req_bad;
      pc_reg <= req_pc;
      x_reg <= req_x;
      y_reg <= req_y;
      b1_reg <= req_byte1;
      b2_reg <= req_byte2;
    end
  end

  // Pointer bytes, high byte first for a word pointer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_hi_reg <= oag_pkg::BYTE_ZERO;
      ptr_lo_reg <= oag_pkg::BYTE_ZERO;
    end
    else
    begin
      if (st_a && mem_ready)
        ptr_hi_reg <= mem_rdata; // see [RQ11]
      if (st_b && mem_ready)
        ptr_lo_reg <= mem_rdata;
    end
  end

  // Operand selection for the adder
  assign idx_val = use_y_reg ? y_reg : x_reg; // see [RQ7]
  assign ptr_word = {ptr_hi_reg, ptr_lo_reg};
  assign is_rel = (mode_reg == oag_pkg::MODE_REL_D) ||
                  (mode_reg == oag_pkg::MODE_REL_I) ||
                  (mode_reg == oag_pkg::MODE_BIT_DR) ||
                  (mode_reg == oag_pkg::MODE_BIT_IR);
  assign is_short_sum = (mode_reg == oag_pkg::MODE_IDX_N) ||
                        (mode_reg == oag_pkg::MODE_IDX_S) ||
                        (mode_reg == oag_pkg::MODE_IIX_S); // see [RQ18]
  assign is_full_sum = (mode_reg == oag_pkg::MODE_IDX_L) ||
                       (mode_reg == oag_pkg::MODE_IIX_L);

  assign sum_bus.kind = is_rel ? oag_pkg::SUM_REL :
                        is_short_sum ? oag_pkg::SUM_SHORT :
                        oag_pkg::SUM_FULL;
  assign sum_bus.base =
    (mode_reg == oag_pkg::MODE_IDX_N) ? {oag_pkg::PAGE0_HI, idx_val} :
    (mode_reg == oag_pkg::MODE_IDX_S) ? {oag_pkg::PAGE0_HI, idx_val} :
    (mode_reg == oag_pkg::MODE_IDX_L) ? {b1_reg, b2_reg} : // see [RQ10]
    (mode_reg == oag_pkg::MODE_IIX_S) ? {oag_pkg::PAGE0_HI, ptr_hi_reg} :
    (mode_reg == oag_pkg::MODE_IIX_L) ? ptr_word : // see [RQ13]
    is_rel ? pc_reg : oag_pkg::ADDR_ZERO; // see [RQ15]
  assign sum_bus.addend =
    (mode_reg == oag_pkg::MODE_IDX_S) ? b1_reg : // see [RQ9]
    is_full_sum ? idx_val :
    (mode_reg == oag_pkg::MODE_IIX_S) ? idx_val : // see [RQ14]
    (mode_reg == oag_pkg::MODE_REL_D) ? b1_reg :
    (mode_reg == oag_pkg::MODE_REL_I) ? ptr_hi_reg :
    (mode_reg == oag_pkg::MODE_BIT_DR) ? b2_reg :
    (mode_reg == oag_pkg::MODE_BIT_IR) ? b2_reg : oag_pkg::BYTE_ZERO;

  // Effective address for each group of modes
  assign ea_next =
    bad_reg ? oag_pkg::ADDR_ZERO :
    (is_short_sum || is_full_sum) ? sum_bus.result : // see [RQ8]
    (mode_reg == oag_pkg::MODE_DIR_S) ?
      {oag_pkg::PAGE0_HI, b1_reg} : // see [RQ5]
    (mode_reg == oag_pkg::MODE_BIT_D) ? {oag_pkg::PAGE0_HI, b1_reg} :
    (mode_reg == oag_pkg::MODE_BIT_DR) ? {oag_pkg::PAGE0_HI, b1_reg} :
    (mode_reg == oag_pkg::MODE_DIR_L) ? {b1_reg, b2_reg} : // see [RQ6]
    (mode_reg == oag_pkg::MODE_IND_S) ?
      {oag_pkg::PAGE0_HI, ptr_hi_reg} : // see [RQ12]
    (mode_reg == oag_pkg::MODE_BIT_I) ? {oag_pkg::PAGE0_HI, ptr_hi_reg} :
    (mode_reg == oag_pkg::MODE_BIT_IR) ? {oag_pkg::PAGE0_HI, ptr_hi_reg} :
    (mode_reg == oag_pkg::MODE_IND_L) ? ptr_word : // see [RQ11]
    oag_pkg::ADDR_ZERO; // see [RQ16]
  assign target_next = (is_rel && !bad_reg) ? sum_bus.result : pc_reg;
  assign imm_next = (mode_reg == oag_pkg::MODE_IMM) ? b1_reg : // see [RQ3]
                    oag_pkg::BYTE_ZERO; // see [RQ4]
  assign len_next = oag_pkg::oag_mode_len(mode_reg, use_y_reg); // see [RQ1]

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      done_reg <= 1'b0;
    else
      done_reg <= st_calc;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ea_reg <= oag_pkg::ADDR_ZERO;
      target_reg <= oag_pkg::ADDR_ZERO;
      imm_reg <= oag_pkg::BYTE_ZERO;
      len_reg <= oag_pkg::LEN_ONE;
      illegal_reg <= 1'b0;
    end
    else if (st_calc)
    begin
      ea_reg <= ea_next;
      target_reg <= target_next;
      imm_reg <= imm_next;
      len_reg <= len_next; // see [RQ2]
      illegal_reg <= bad_reg;
    end
  end

  assign done = done_reg;
  assign ea = ea_reg;
  assign target = target_reg;
  assign imm_data = imm_reg;
  assign inst_len = len_reg;
  assign illegal = illegal_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  no_ptr_latency_a: assert property ( // see [RQ3]
    req_fire && !req_ptr |-> !mem_rd ##1 !mem_rd ##1 done)
    else $error("direct request not done two cycles after accept");
  ptr_page0_a: assert property ( // see [RQ11]
    mem_rd |-> mem_addr[15:8] == oag_pkg::PAGE0_HI)
    else $error("pointer fetch left page zero");
  inh_len_a: assert property ( // see [RQ2]
    done && mode_reg == oag_pkg::MODE_INH && !illegal |-> inst_len == 3'h1)
    else $error("inherent length wrong");
  imm_operand_a: assert property ( // see [RQ4]
    done && mode_reg == oag_pkg::MODE_IMM && !illegal
    |-> imm_data == b1_reg && inst_len == 3'h2)
    else $error("immediate operand or length wrong");
  noofs_len_a: assert property ( // see [RQ8]
    done && mode_reg == oag_pkg::MODE_IDX_N
    |-> inst_len == (use_y_reg ? 3'h2 : 3'h1) &&
        ea <= oag_pkg::PAGE0_MAX)
    else $error("no-offset indexed length or range wrong");
  short_idx_a: assert property ( // see [RQ9]
    done && mode_reg == oag_pkg::MODE_IDX_S
    |-> ea == ({8'h00, b1_reg} + {8'h00, idx_val}) &&
        ea <= oag_pkg::SHORT_SUM_MAX)
    else $error("short indexed sum wrong");
  long_idx_a: assert property ( // see [RQ10]
    done && mode_reg == oag_pkg::MODE_IDX_L && !illegal
    |-> ea == {b1_reg, b2_reg} + {8'h00, idx_val})
    else $error("long indexed sum wrong");
  dir_short_a: assert property ( // see [RQ5]
    done && mode_reg == oag_pkg::MODE_DIR_S && !illegal
    |-> ea == {8'h00, b1_reg})
    else $error("short direct address wrong");
  rel_target_a: assert property ( // see [RQ15]
    done && mode_reg == oag_pkg::MODE_REL_D && !illegal
    |-> target == pc_reg + {{8{b1_reg[7]}}, b1_reg})
    else $error("relative target wrong");
  iix_long_a: assert property ( // see [RQ13]
    done && mode_reg == oag_pkg::MODE_IIX_L && !illegal
    |-> ea == {ptr_hi_reg, ptr_lo_reg} + {8'h00, idx_val})
    else $error("indirect indexed sum wrong");
  rmw_long_a: assert property ( // see [RQ17]
    req_fire && req_rmw && req_mode == oag_pkg::MODE_DIR_L
    |-> ##2 done && illegal && ea == 16'h0000)
    else $error("long form accepted for read-modify-write");

  iix_long_c: cover property (
    done && mode_reg == oag_pkg::MODE_IIX_L && !illegal);
  rel_ind_c: cover property (
    done && mode_reg == oag_pkg::MODE_REL_I && !illegal);
  short_carry_c: cover property (
    done && mode_reg == oag_pkg::MODE_IDX_S && ea[8]);
  illegal_c: cover property (done && illegal);

endmodule

// ---- tb/oag_mem_model.sv ----
// Page-zero memory model answering pointer byte fetches
`timescale 1ns/10ps
module oag_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Pointer fetch port
  input wire logic mem_rd,
  input wire logic [15:0] mem_addr,
  output logic mem_ready,
  output logic [7:0] mem_rdata,
  // Wait cycles before each byte is answered
  input wire logic [3:0] wait_cyc
);
  logic [7:0] mem [256];
  logic [3:0] cnt_reg;
  logic [7:0] last_reg;
  wire hit = mem_rd && (cnt_reg == wait_cyc);
  wire page0 = (mem_addr[15:8] == 8'h00);

  initial foreach (mem[i]) mem[i] = 8'h00;

  // Off page zero or not answering: data is not the last value
  assign mem_ready = hit;
  assign mem_rdata = (hit && page0) ? mem[mem_addr[7:0]] : ~last_reg;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      cnt_reg <= 4'h0;
      last_reg <= 8'h00;
    end
    else if (hit)
    begin
      cnt_reg <= 4'h0;
      last_reg <= mem_rdata;
    end
    else if (mem_rd)
      cnt_reg <= cnt_reg + 4'h1;
endmodule

// ---- tb/operand_address_generator_tb.sv ----
// Self-checking bench for the operand address generator
`timescale 1ns/10ps
module operand_address_generator_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic [4:0] req_mode = 5'h00;
  logic req_use_y = 1'b0;
  logic req_rmw = 1'b0;
  logic [15:0] req_pc = 16'h1000;
  logic [7:0] req_x = 8'h00;
  logic [7:0] req_y = 8'h00;
  logic [7:0] req_byte1 = 8'h00;
  logic [7:0] req_byte2 = 8'h00;
  logic [3:0] wait_cyc = 4'h0;
  logic req_ready, mem_rd, mem_ready, done, illegal;
  logic [15:0] mem_addr, ea, target;
  logic [7:0] mem_rdata, imm_data;
  logic [2:0] inst_len;
  int num_errors = 0;
  int checked = 0;
  int lat;
  int rd_cycles;

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (mem_rd === 1'b1) rd_cycles++;

  oag_addr_gen dut (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_mode(req_mode), .req_use_y(req_use_y),
    .req_rmw(req_rmw), .req_pc(req_pc), .req_x(req_x), .req_y(req_y),
    .req_byte1(req_byte1), .req_byte2(req_byte2), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .done(done), .ea(ea), .target(target), .imm_data(imm_data),
    .inst_len(inst_len), .illegal(illegal));
  oag_mem_model mm (.clk_sys(clk_sys), .nrst(nrst), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .wait_cyc(wait_cyc));

  task automatic close_out();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_addr({8'h00, got}, {8'h00, exp});
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    chk_addr({15'h0000, got}, {15'h0000, exp});
  endtask

  // One request, raised once ready and dropped after one cycle; results read in the done cycle
  task automatic go(input logic [4:0] m, input logic y, input logic rmw,
                    input logic [7:0] b1, input logic [7:0] b2);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk_sys);
      n++;
    end
    req_mode = m;
    req_use_y = y;
    req_rmw = rmw;
    req_byte1 = b1;
    req_byte2 = b2;
    req_valid = 1'b1;
    rd_cycles = 0;
    @(negedge clk_sys);
    req_valid = 1'b0;
    lat = 1;
    while (done !== 1'b1 && lat < 50)
    begin
      @(negedge clk_sys);
      lat++;
    end
    if (done !== 1'b1 || n >= 50)
    begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, done, 1'b1);
      close_out();
    end
  endtask

  task automatic res(input logic [15:0] e, input logic [15:0] t,
                     input logic [2:0] len, input logic ill);
    chk_addr(ea, e);
    chk_addr(target, t);
    chk_byte({5'h00, inst_len}, {5'h00, len});
    chk_flag(illegal, ill);
  endtask

  task automatic t_lengths();
    logic [2:0] el [17] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h1, 3'h2, 3'h3, 3'h3,
      3'h3, 3'h3, 3'h3, 3'h2, 3'h3, 3'h2, 3'h3, 3'h3, 3'h4};
    for (int i = 0; i < 17; i++)
    begin
      go(i[4:0], 1'b0, 1'b0, 8'h10, 8'h00);
      chk_byte({5'h00, inst_len}, {5'h00, el[i]});
      chk_flag(illegal, 1'b0);
    end
    go(5'h11, 1'b0, 1'b0, 8'h10, 8'h00);
    res(16'h0000, req_pc, 3'h1, 1'b1);
    $display("lengths done");
  endtask

  task automatic t_simple();
    go(oag_pkg::MODE_IMM, 1'b0, 1'b0, 8'hA5, 8'h5A);
    chk_byte(imm_data, 8'hA5);
    chk_byte(rd_cycles[7:0], 8'h00);
    res(16'h0000, req_pc, 3'h2, 1'b0);
    go(oag_pkg::MODE_INH, 1'b0, 1'b0, 8'hA5, 8'h00);
    res(16'h0000, req_pc, 3'h1, 1'b0);
    chk_byte(imm_data, 8'h00);
    go(oag_pkg::MODE_DIR_S, 1'b0, 1'b0, 8'hFF, 8'h00);
    res(16'h00FF, req_pc, 3'h2, 1'b0);
    chk_byte(lat[7:0], 8'h02);
    go(oag_pkg::MODE_DIR_L, 1'b0, 1'b0, 8'h12, 8'h34);
    res(16'h1234, req_pc, 3'h3, 1'b0);
    $display("immediate and direct done");
  endtask

  task automatic t_indexed();
    req_x = 8'hFF;
    req_y = 8'h01;
    go(oag_pkg::MODE_IDX_N, 1'b0, 1'b0, 8'h00, 8'h00);
    res(16'h00FF, req_pc, 3'h1, 1'b0);
    go(oag_pkg::MODE_IDX_N, 1'b1, 1'b0, 8'h00, 8'h00);
    res(16'h0001, req_pc, 3'h2, 1'b0);
    req_y = 8'hFF;
    go(oag_pkg::MODE_IDX_S, 1'b1, 1'b0, 8'hFF, 8'h00);
    res(16'h01FE, req_pc, 3'h2, 1'b0);
    req_x = 8'h20;
    go(oag_pkg::MODE_IDX_L, 1'b0, 1'b0, 8'h12, 8'hF0);
    res(16'h1310, req_pc, 3'h3, 1'b0);
    $display("indexed done");
  endtask

  task automatic t_indirect();
    mm.mem[8'h10] = 8'h80;
    go(oag_pkg::MODE_IND_S, 1'b0, 1'b0, 8'h10, 8'h00);
    res(16'h0080, req_pc, 3'h3, 1'b0);
    chk_byte(lat[7:0], 8'h03);
    mm.mem[8'hFF] = 8'hAB;
    mm.mem[8'h00] = 8'hCD;
    wait_cyc = 4'h2;
    go(oag_pkg::MODE_IND_L, 1'b0, 1'b0, 8'hFF, 8'h00);
    res(16'hABCD, req_pc, 3'h3, 1'b0);
    chk_byte(lat[7:0], 8'h08);
    wait_cyc = 4'h0;
    mm.mem[8'h30] = 8'hFF;
    go(oag_pkg::MODE_IIX_S, 1'b1, 1'b0, 8'h30, 8'h00);
    res(16'h01FE, req_pc, 3'h3, 1'b0);
    mm.mem[8'h40] = 8'h12;
    mm.mem[8'h41] = 8'hF0;
    go(oag_pkg::MODE_IIX_L, 1'b0, 1'b0, 8'h40, 8'h00);
    res(16'h1310, req_pc, 3'h3, 1'b0);
    chk_byte(lat[7:0], 8'h04);
    $display("indirect done");
  endtask

  task automatic t_relative();
    go(oag_pkg::MODE_REL_D, 1'b0, 1'b0, 8'h80, 8'h00);
    res(16'h0000, 16'h0F80, 3'h2, 1'b0);
    go(oag_pkg::MODE_REL_D, 1'b0, 1'b0, 8'h7F, 8'h00);
    res(16'h0000, 16'h107F, 3'h2, 1'b0);
    mm.mem[8'h50] = 8'hFE;
    go(oag_pkg::MODE_REL_I, 1'b0, 1'b0, 8'h50, 8'h00);
    res(16'h0000, 16'h0FFE, 3'h3, 1'b0);
    go(oag_pkg::MODE_BIT_D, 1'b0, 1'b1, 8'h10, 8'h00);
    res(16'h0010, req_pc, 3'h2, 1'b0);
    mm.mem[8'h70] = 8'h44;
    go(oag_pkg::MODE_BIT_I, 1'b0, 1'b1, 8'h70, 8'h00);
    res(16'h0044, req_pc, 3'h3, 1'b0);
    go(oag_pkg::MODE_BIT_DR, 1'b0, 1'b1, 8'h10, 8'h05);
    res(16'h0010, 16'h1005, 3'h3, 1'b0);
    mm.mem[8'h60] = 8'h33;
    go(oag_pkg::MODE_BIT_IR, 1'b0, 1'b1, 8'h60, 8'h80);
    res(16'h0033, 16'h0F80, 3'h4, 1'b0);
    $display("relative and bit done");
  endtask

  task automatic t_rmw();
    logic [4:0] lng [5] = '{5'h01, 5'h03, 5'h06, 5'h08, 5'h0A};
    logic [4:0] sht [4] = '{5'h02, 5'h05, 5'h07, 5'h09};
    foreach (lng[i])
    begin
      go(lng[i], 1'b0, 1'b1, 8'h10, 8'h00);
      chk_flag(illegal, 1'b1);
      chk_addr(ea, 16'h0000);
      chk_byte(rd_cycles[7:0], 8'h00);
    end
    foreach (sht[i])
    begin
      go(sht[i], 1'b0, 1'b1, 8'h10, 8'h00);
      chk_flag(illegal, 1'b0);
      chk_flag(ea[15:9] == 7'h00, 1'b1);
    end
    $display("read-modify-write done");
  endtask

  initial
  begin
    repeat (10) @(negedge clk_sys);
    chk_flag(req_ready, 1'b1);
    chk_flag(done, 1'b0);
    res(16'h0000, 16'h0000, 3'h1, 1'b0);
    nrst = 1'b1;
    $display("reset done");
    t_lengths();
    t_simple();
    t_indexed();
    t_indirect();
    t_relative();
    t_rmw();
    close_out();
  end
endmodule
